// >>> tb/spmsp_peer.sv
// far-side peripheral model that shifts one word against the port's clock
module spmsp_peer (
  input wire logic sck,
  input wire logic sdo,
  input wire logic load,
  input wire logic [15:0] loadWord,
  input wire logic wide,
  output logic sdi,
  output logic [15:0] rxWord
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] txReg = 16'h0000;
  initial rxWord = 16'h0000;
  // idle-low clock: sample on the rising edge, shift on the falling one
  always @(posedge sck) begin
    rxWord <= {rxWord[14:0], sdo};
  end
  always @(negedge sck or posedge load) begin
    if (load) begin
      txReg <= loadWord;
    end else begin
      txReg <= txReg << 1;
    end
  end
  assign sdi = wide ? txReg[15] : txReg[7];
endmodule : spmsp_peer

// >>> tb/tb_top.sv
// self-checking bench for the serial port in master mode
`include "spmsp_regs.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, xferIrq, err;
  logic serialClockPinIn, slaveSelectPinIn, cpuSleep, cpuIdle, serialInPin;
  logic peerLoad, wideMode, sdoOff, oeSeen, mRxFull, mOv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, r;
  logic [15:0] peerWord, peerRx, mask, mRx;
  spmsp_pkg::spmsp_pins_s pinsOut;
  int miscompares, nCompared;
  wire sck = pinsOut.sckOeN ? 1'b0 : pinsOut.sckOut;
  // released data-out floats to its pull-up level
  wire sdo = pinsOut.sdoOeN ? 1'b1 : pinsOut.sdoOut;

  spmsp_port spmsp_port_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClockPinIn(serialClockPinIn), .serialInPin(serialInPin),
    .slaveSelectPinIn(slaveSelectPinIn), .cpuSleep(cpuSleep), .cpuIdle(cpuIdle),
    .pinsOut(pinsOut), .xferIrq(xferIrq));
  spmsp_peer spmsp_peer_i (.sck(sck), .sdo(sdo), .load(peerLoad), .loadWord(peerWord),
    .wide(wideMode), .sdi(serialInPin), .rxWord(peerRx));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic stopTest();
    $display("compared %0d, mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stopTest

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // request held until pready is seen high at a falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // look at the settled answer before the edge that takes it
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic xfer(input logic [15:0] tx, input logic [15:0] pw);
    int n;
    mask = wideMode ? 16'hFFFF : 16'h00FF;
    @(posedge sys_clk);
    peerWord <= pw;
    @(posedge sys_clk);
    peerLoad <= 1'b1;
    @(posedge sys_clk);
    peerLoad <= 1'b0;
    apb(1'b1, `SPMSP_ADDR_BUFFER, {16'h0000, tx});
    repeat (20) @(posedge sys_clk);
    oeSeen = pinsOut.sdoOeN;
    `CHK(pinsOut.sckOeN, 1'b0)
    `CHK(oeSeen, sdoOff)
    n = 0;
    while (xferIrq !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(xferIrq, 1'b1)
    // lets the final clock edge return the line to idle
    repeat (12) @(posedge sys_clk);
    `CHK(peerRx & mask, sdoOff ? mask : tx & mask)
    if (mRxFull) begin
      mOv = 1'b1;
    end else begin
      mRx = pw & mask;
      mRxFull = 1'b1;
    end
    apb(1'b1, `SPMSP_ADDR_IRQ, 32'h0000_0002);
    @(posedge sys_clk);
    `CHK(xferIrq, 1'b0)
  endtask : xfer

  task automatic readBack();
    apb(1'b0, `SPMSP_ADDR_BUFFER, 32'h0);
    `CHK(rd, {16'h0000, mRx})
    mRxFull = 1'b0;
    mOv = 1'b0;
  endtask : readBack

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    serialClockPinIn = 1'b0;
    slaveSelectPinIn = 1'b1;
    cpuSleep = 1'b0;
    cpuIdle = 1'b0;
    peerLoad = 1'b0;
    peerWord = 16'h0000;
    wideMode = 1'b0;
    sdoOff = 1'b0;
    seed = 32'h6;
    mRx = 16'h0000;
    mRxFull = 1'b0;
    mOv = 1'b0;
    miscompares = 0;
    nCompared = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(`SPMSP_ADDR_STATUS + i * 8), 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 12'h004, 32'h0);
    `CHK(err, 1'b1)
    $display("test reset done");
    // master, sample on leading edge, four system clocks per half bit
    apb(1'b1, `SPMSP_ADDR_CONTROL, 32'h0000_013E);
    apb(1'b0, `SPMSP_ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_013E)
    apb(1'b1, `SPMSP_ADDR_STATUS, 32'h0000_8000);
    apb(1'b1, `SPMSP_ADDR_IRQ, 32'h0000_0002);
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      xfer(r[15:0], r[31:16]);
      readBack();
    end
    $display("test byte transfer done");
    r = rnd();
    xfer(r[15:0], r[31:16]);
    xfer(r[31:16], r[15:0]);
    apb(1'b0, `SPMSP_ADDR_STATUS, 32'h0);
    `CHK(rd[6], mOv)
    readBack();
    apb(1'b0, `SPMSP_ADDR_STATUS, 32'h0);
    `CHK(rd[6], 1'b0)
    $display("test overflow done");
    apb(1'b1, `SPMSP_ADDR_STATUS, 32'h0);
    apb(1'b1, `SPMSP_ADDR_CONTROL, 32'h0000_053E);
    wideMode <= 1'b1;
    apb(1'b1, `SPMSP_ADDR_STATUS, 32'h0000_8000);
    r = rnd();
    xfer(r[15:0], r[31:16]);
    readBack();
    $display("test word transfer done");
    apb(1'b1, `SPMSP_ADDR_CONTROL, 32'h0000_0D3E);
    sdoOff = 1'b1;
    r = rnd();
    xfer(r[15:0], r[31:16]);
    readBack();
    $display("test output disable done");
    stopTest();
  end

  // run needs under a thousand cycles; this margin only catches a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    stopTest();
  end
endmodule : tb_top

// >>> verilog/spmsp_pkg.sv
// types shared by the serial port design
package spmsp_pkg;

  typedef struct packed {
    logic rsv15;
    logic framingEnable;
    logic frameSyncDirection;
    logic rsv12;
    logic serialOutDisable;
    logic wordSizeSelect;
    logic inputSamplePhase;
    logic clockEdgeSelect;
    logic selectControlEnable;
    logic clockIdlePolarity;
    logic masterSelect;
    logic [2:0] secondaryPrescale;
    logic [1:0] primaryPrescale;
  } spmsp_ctrl_s;

  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic sdoOut;
    logic sdoOeN;
    logic ssOut;
    logic ssOeN;
  } spmsp_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_SHIFT
  } spmsp_state_e;

endpackage : spmsp_pkg

// >>> verilog/spmsp_port.sv
// serial peripheral port, master or slave, with apb register access
//
// Overview of operation
// - one 16-bit shift register plus buffer
// - master drives clock pin, slave receives it
// - 8 or 16 pulses shift out and in
// - completion sets flag; irq only when enabled
// - completed word copied to receive buffer
// - full receive buffer sets overflow, drops word
// - overflow freezes port until buffer read
// - written transmit word loaded for next transfer
// - one address: write transmit, read receive
// - master starts on write, flag on last bit's sample edge
// - slave shifts on external edges, flag on latch
// - bit clock is half clock through prescalers
// - edge select and idle polarity bits
// - word size picks out bit 15 or 7
// - word size change resets the port
// - disable bit releases data-out pin
// - framing turns select into sync, direction bit
// - one-cycle high sync, data on next edge
// - slave with select control needs select low
// - select high releases output, restarts transfer
// - sleep aborts transfer, keeps register contents
// - stop-in-idle bit freezes port in idle
`include "spmsp_regs.svh"

module spmsp_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialClockPinIn,
  input wire logic serialInPin,
  input wire logic slaveSelectPinIn,
  input wire logic cpuSleep,
  input wire logic cpuIdle,
  output spmsp_pkg::spmsp_pins_s pinsOut,
  output logic xferIrq
);
  import spmsp_pkg::*;

  spmsp_ctrl_s ctrl_reg, ctrl_next;
  logic portEnable_reg, portEnable_next, stopInIdle_reg, stopInIdle_next;
  logic overflow_reg, overflow_next, rxFull_reg, rxFull_next, txFull_reg, txFull_next;
  logic [15:0] txBuf_reg, txBuf_next, rxBuf_reg, rxBuf_next, shift_reg, shift_next;
  logic doneFlag_reg, doneFlag_next, doneIe_reg, doneIe_next;
  spmsp_state_e state_reg, state_next;
  logic [4:0] edgeCnt_reg, edgeCnt_next;
  logic sampled_reg, sampled_next, sckLvl_reg, sckLvl_next, sckPrev_reg, sckPrev_next;
  logic [9:0] divCnt_reg, divCnt_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
  spmsp_pins_s pins_reg, pins_next;

  logic setupPhase, wrAcc, rdAcc, hitStatus, hitControl, hitBuffer, hitIrq;
  logic running, modeChange, slaveDeselect, abort, edgeOk, isLead;
  logic sampleEdge, shiftEdge, xferDone, framed;
  logic [4:0] lastEdge;
  logic [9:0] priDiv, halfTicks;
  logic [15:0] doneWord;

  assign setupPhase = psel & ~penable;
  assign wrAcc = psel & penable & pready_reg & pwrite;
  assign rdAcc = psel & penable & pready_reg & ~pwrite;
  assign hitStatus = paddr == `SPMSP_ADDR_STATUS;
  assign hitControl = paddr == `SPMSP_ADDR_CONTROL;
  assign hitBuffer = paddr == `SPMSP_ADDR_BUFFER;
  assign hitIrq = paddr == `SPMSP_ADDR_IRQ;
  assign framed = ctrl_reg.framingEnable;

  // idle freeze holds state, sleep aborts it
  assign running = portEnable_reg & ~cpuSleep & ~(cpuIdle & stopInIdle_reg);
  assign modeChange = wrAcc & hitControl &
    (pwdata[`SPMSP_CTRL_WORD_SIZE] != ctrl_reg.wordSizeSelect);
  assign slaveDeselect = ~ctrl_reg.masterSelect & ctrl_reg.selectControlEnable &
    ~framed & slaveSelectPinIn;
  assign abort = ~portEnable_reg | cpuSleep | modeChange | slaveDeselect;
  assign lastEdge = ctrl_reg.wordSizeSelect ? `SPMSP_LAST_EDGE16 : `SPMSP_LAST_EDGE8;

  // divide codes are fixed integers on the half-rate clock
  always_comb begin
    case (ctrl_reg.primaryPrescale)
      2'h0: priDiv = `SPMSP_PRI_DIV0;
      2'h1: priDiv = `SPMSP_PRI_DIV1;
      2'h2: priDiv = `SPMSP_PRI_DIV2;
      default: priDiv = `SPMSP_PRI_DIV3;
    endcase
    halfTicks = 10'(priDiv * (`SPMSP_SEC_BASE - {7'h00, ctrl_reg.secondaryPrescale}));
  end

  // master toggles every halfTicks cycles: bit period is two half periods of fosc/2 steps
  always_comb begin
    if (ctrl_reg.masterSelect) begin
      edgeOk = running & ~overflow_reg & (state_reg != ST_IDLE) & (divCnt_reg == 10'h000);
      isLead = sckLvl_reg == ctrl_reg.clockIdlePolarity;
    end else begin
      edgeOk = running & ~overflow_reg & (serialClockPinIn != sckPrev_reg);
      isLead = serialClockPinIn != ctrl_reg.clockIdlePolarity;
    end
  end

  // even edges lead; edge select picks which parity moves data
  always_comb begin
    sampleEdge = ctrl_reg.clockEdgeSelect ? ~edgeCnt_reg[0] : edgeCnt_reg[0];
    shiftEdge = ~sampleEdge & (edgeCnt_reg != lastEdge) &
      ~(~ctrl_reg.clockEdgeSelect & (edgeCnt_reg == 5'h00));
    xferDone = edgeOk & (state_reg == ST_SHIFT) & sampleEdge &
      (edgeCnt_reg >= lastEdge - 5'h01);
    if (ctrl_reg.wordSizeSelect) begin
      doneWord = {shift_reg[14:0], serialInPin};
    end else begin
      doneWord = {8'h00, shift_reg[6:0], serialInPin};
    end
  end

  always_comb begin
    state_next = state_reg;
    edgeCnt_next = edgeCnt_reg;
    shift_next = shift_reg;
    sampled_next = sampled_reg;
    sckLvl_next = sckLvl_reg;
    sckPrev_next = serialClockPinIn;
    divCnt_next = divCnt_reg;
    txFull_next = txFull_reg;
    if (abort) begin
      state_next = ST_IDLE;
      edgeCnt_next = 5'h00;
      sckLvl_next = ctrl_reg.clockIdlePolarity;
      divCnt_next = 10'h000;
    end else if (running) begin
      if (ctrl_reg.masterSelect && state_reg != ST_IDLE && !overflow_reg) begin
        divCnt_next = (divCnt_reg == 10'h000) ? halfTicks - 10'h001 : divCnt_reg - 10'h001;
        if (edgeOk) begin
          sckLvl_next = ~sckLvl_reg;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          sckLvl_next = ctrl_reg.clockIdlePolarity;
          edgeCnt_next = 5'h00;
          if (ctrl_reg.masterSelect) begin
            if (txFull_reg && !overflow_reg &&
                (!framed || !ctrl_reg.frameSyncDirection || slaveSelectPinIn)) begin
              shift_next = txBuf_reg;
              txFull_next = 1'b0;
              divCnt_next = halfTicks - 10'h001;
              state_next = framed ? ST_FRAME : ST_SHIFT;
            end
          end else if (!overflow_reg) begin
            if (txFull_reg) begin
              shift_next = txBuf_reg;
              txFull_next = 1'b0;
            end
            state_next = framed ? ST_FRAME : ST_SHIFT;
          end
        end
        ST_FRAME: begin
          // sync cycle: lead edge opens it, trail edge ends it, no data moves
          if (edgeOk) begin
            if (edgeCnt_reg == 5'h00) begin
              if (ctrl_reg.masterSelect || (isLead && slaveSelectPinIn)) begin
                edgeCnt_next = 5'h01;
              end
            end else begin
              edgeCnt_next = 5'h00;
              state_next = ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          if (edgeOk) begin
            if (sampleEdge) begin
              sampled_next = serialInPin;
            end
            if (shiftEdge) begin
              shift_next = {shift_reg[14:0], sampled_reg};
            end
            if (edgeCnt_reg == lastEdge) begin
              state_next = ST_IDLE;
              edgeCnt_next = 5'h00;
            end else begin
              edgeCnt_next = edgeCnt_reg + 5'h01;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    if (modeChange) begin
      txFull_next = 1'b0;
    end
    if (wrAcc && hitBuffer) begin
      txFull_next = 1'b1;
    end
  end

  // software side; hardware sets win over software clears
  always_comb begin
    ctrl_next = ctrl_reg;
    portEnable_next = portEnable_reg;
    stopInIdle_next = stopInIdle_reg;
    overflow_next = overflow_reg;
    rxFull_next = rxFull_reg;
    rxBuf_next = rxBuf_reg;
    txBuf_next = txBuf_reg;
    doneFlag_next = doneFlag_reg;
    doneIe_next = doneIe_reg;
    if (wrAcc && hitStatus) begin
      portEnable_next = pwdata[`SPMSP_STAT_ENABLE];
      stopInIdle_next = pwdata[`SPMSP_STAT_STOP_IDLE];
      if (!pwdata[`SPMSP_STAT_OVERFLOW]) begin
        overflow_next = 1'b0;
      end
    end
    if (wrAcc && hitControl) begin
      ctrl_next = spmsp_ctrl_s'(pwdata[15:0] & `SPMSP_CTRL_WRITE_MASK);
    end
    if (wrAcc && hitBuffer) begin
      txBuf_next = pwdata[15:0];
    end
    if (wrAcc && hitIrq) begin
      doneIe_next = pwdata[`SPMSP_IRQ_ENABLE];
      if (!pwdata[`SPMSP_IRQ_FLAG]) begin
        doneFlag_next = 1'b0;
      end
    end
    if (rdAcc && hitBuffer) begin
      rxFull_next = 1'b0;
      overflow_next = 1'b0;
    end
    if (modeChange) begin
      rxFull_next = 1'b0;
      overflow_next = 1'b0;
    end
    if (xferDone) begin
      doneFlag_next = 1'b1;
      if (rxFull_reg) begin
        overflow_next = 1'b1;
      end else begin
        rxBuf_next = doneWord;
        rxFull_next = 1'b1;
      end
    end
  end

  // apb: answer is ready in the first access cycle, unmapped gives slverr
  always_comb begin
    pready_next = setupPhase;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (setupPhase) begin
      if (hitStatus) begin
        prdata_next[`SPMSP_STAT_ENABLE] = portEnable_reg;
        prdata_next[`SPMSP_STAT_STOP_IDLE] = stopInIdle_reg;
        prdata_next[`SPMSP_STAT_OVERFLOW] = overflow_reg;
        prdata_next[`SPMSP_STAT_TX_FULL] = txFull_reg;
        prdata_next[`SPMSP_STAT_RX_FULL] = rxFull_reg;
      end else if (hitControl) begin
        prdata_next[15:0] = ctrl_reg;
      end else if (hitBuffer) begin
        prdata_next[15:0] = rxBuf_reg;
      end else if (hitIrq) begin
        prdata_next[`SPMSP_IRQ_ENABLE] = doneIe_reg;
        prdata_next[`SPMSP_IRQ_FLAG] = doneFlag_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  // pins are registered so every output comes from a flop
  always_comb begin
    pins_next.sckOut = ctrl_reg.masterSelect ? sckLvl_next : 1'b0;
    pins_next.sckOeN = ~(portEnable_reg & ctrl_reg.masterSelect);
    pins_next.sdoOut = ctrl_reg.wordSizeSelect ? shift_next[15] : shift_next[7];
    pins_next.sdoOeN = ~(portEnable_reg & ~ctrl_reg.serialOutDisable & ~slaveDeselect);
    pins_next.ssOut = ctrl_reg.masterSelect & (state_next == ST_FRAME);
    pins_next.ssOeN = ~(portEnable_reg & framed & ctrl_reg.masterSelect &
      ~ctrl_reg.frameSyncDirection);
    irq_next = doneFlag_next & doneIe_next;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= spmsp_ctrl_s'(`SPMSP_RESET_VALUE);
      portEnable_reg <= 1'b0;
      stopInIdle_reg <= 1'b0;
      overflow_reg <= 1'b0;
      rxFull_reg <= 1'b0;
      txFull_reg <= 1'b0;
      txBuf_reg <= `SPMSP_RESET_VALUE;
      rxBuf_reg <= `SPMSP_RESET_VALUE;
      shift_reg <= `SPMSP_RESET_VALUE;
      doneFlag_reg <= 1'b0;
      doneIe_reg <= 1'b0;
      state_reg <= ST_IDLE;
      edgeCnt_reg <= 5'h00;
      sampled_reg <= 1'b0;
      sckLvl_reg <= 1'b0;
      sckPrev_reg <= 1'b0;
      divCnt_reg <= 10'h000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      pins_reg <= 6'h15;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      portEnable_reg <= portEnable_next;
      stopInIdle_reg <= stopInIdle_next;
      overflow_reg <= overflow_next;
      rxFull_reg <= rxFull_next;
      txFull_reg <= txFull_next;
      txBuf_reg <= txBuf_next;
      rxBuf_reg <= rxBuf_next;
      shift_reg <= shift_next;
      doneFlag_reg <= doneFlag_next;
      doneIe_reg <= doneIe_next;
      state_reg <= state_next;
      edgeCnt_reg <= edgeCnt_next;
      sampled_reg <= sampled_next;
      sckLvl_reg <= sckLvl_next;
      sckPrev_reg <= sckPrev_next;
      divCnt_reg <= divCnt_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      pins_reg <= pins_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pinsOut = pins_reg;
  assign xferIrq = irq_reg;

  property p_overflow_drop;
    @(posedge sys_clk) disable iff (!rstn)
    xferDone && rxFull_reg && !modeChange |=> overflow_reg && $stable(rxBuf_reg);
  endproperty
  a_overflow_drop: assert property (p_overflow_drop) else $error("overflow not flagged");

  property p_rx_copy;
    @(posedge sys_clk) disable iff (!rstn)
    xferDone && !rxFull_reg |=> rxFull_reg && rxBuf_reg == $past(doneWord);
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("received word not buffered");

  property p_overflow_freeze;
    @(posedge sys_clk) disable iff (!rstn)
    overflow_reg && !abort ##1 overflow_reg |-> $stable(edgeCnt_reg) && $stable(shift_reg);
  endproperty
  a_overflow_freeze: assert property (p_overflow_freeze) else $error("moved in overflow");

  property p_irq_raise;
    @(posedge sys_clk) disable iff (!rstn)
    xferDone && doneIe_reg && !(wrAcc && hitIrq) |=> xferIrq && doneFlag_reg;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq missing after transfer");

  property p_deselect;
    @(posedge sys_clk) disable iff (!rstn)
    slaveDeselect |=> pinsOut.sdoOeN && state_reg == ST_IDLE && edgeCnt_reg == 5'h00;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect did not restart");

  property p_sleep_abort;
    @(posedge sys_clk) disable iff (!rstn)
    cpuSleep |=> state_reg == ST_IDLE && $stable(rxBuf_reg) && $stable(ctrl_reg);
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

  property p_clock_dir;
    @(posedge sys_clk) disable iff (!rstn)
    portEnable_reg |=> pinsOut.sckOeN == !$past(ctrl_reg.masterSelect);
  endproperty
  a_clock_dir: assert property (p_clock_dir) else $error("clock pin direction wrong");

  property p_sdo_disable;
    @(posedge sys_clk) disable iff (!rstn)
    ctrl_reg.serialOutDisable |=> pinsOut.sdoOeN;
  endproperty
  a_sdo_disable: assert property (p_sdo_disable) else $error("data-out driven");

  property p_buffer_read;
    @(posedge sys_clk) disable iff (!rstn)
    setupPhase && hitBuffer |=> pready && prdata[15:0] == $past(rxBuf_reg);
  endproperty
  a_buffer_read: assert property (p_buffer_read) else $error("buffer read wrong");

  property p_mode_reset;
    @(posedge sys_clk) disable iff (!rstn)
    modeChange && !xferDone |=> !rxFull_reg && !overflow_reg && state_reg == ST_IDLE;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("word size change no reset");

  property p_done_count;
    @(posedge sys_clk) disable iff (!rstn)
    xferDone |-> edgeCnt_reg == lastEdge || edgeCnt_reg == lastEdge - 5'h01;
  endproperty
  a_done_count: assert property (p_done_count) else $error("word length wrong");

  c_master_done: cover property (@(posedge sys_clk) ctrl_reg.masterSelect && xferDone);
  c_slave_done: cover property (@(posedge sys_clk) !ctrl_reg.masterSelect && xferDone);
  c_overflow: cover property (@(posedge sys_clk) xferDone && rxFull_reg);
  c_framed: cover property (@(posedge sys_clk) state_reg == ST_FRAME ##1 state_reg == ST_SHIFT);

endmodule : spmsp_port

// >>> verilog/spmsp_regs.svh
// register map, field positions, reset values and clock divider constants
`ifndef SPMSP_REGS_SVH
`define SPMSP_REGS_SVH

`define SPMSP_IDX_STATUS 12'h240
`define SPMSP_IDX_CONTROL 12'h242
`define SPMSP_IDX_BUFFER 12'h244
`define SPMSP_IDX_IRQ 12'h246
`define SPMSP_ADDR_STATUS 12'(`SPMSP_IDX_STATUS * 4)
`define SPMSP_ADDR_CONTROL 12'(`SPMSP_IDX_CONTROL * 4)
`define SPMSP_ADDR_BUFFER 12'(`SPMSP_IDX_BUFFER * 4)
`define SPMSP_ADDR_IRQ 12'(`SPMSP_IDX_IRQ * 4)

`define SPMSP_STAT_ENABLE 15
`define SPMSP_STAT_STOP_IDLE 13
`define SPMSP_STAT_OVERFLOW 6
`define SPMSP_STAT_TX_FULL 1
`define SPMSP_STAT_RX_FULL 0
`define SPMSP_CTRL_WORD_SIZE 10
`define SPMSP_CTRL_WRITE_MASK 16'h6FFF
`define SPMSP_IRQ_FLAG 0
`define SPMSP_IRQ_ENABLE 1
`define SPMSP_RESET_VALUE 16'h0000

`define SPMSP_PRI_DIV0 10'h040
`define SPMSP_PRI_DIV1 10'h010
`define SPMSP_PRI_DIV2 10'h004
`define SPMSP_PRI_DIV3 10'h001
`define SPMSP_SEC_BASE 10'h008
`define SPMSP_LAST_EDGE8 5'h0F
`define SPMSP_LAST_EDGE16 5'h1F

`endif
